//--- core/lsf_cfg.svh
// lsf_cfg.svh: constants of the line sync and field identification block
// assumes inclusion by bare name from the package only
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH

// counter and window widths
`define LSF_CNT_W      12
`define LSF_AGE_W      7

// hsync/vsync coincidence window in pixel clock cycles
`define LSF_SKEW_CYC   7'h40
`define LSF_AGE_MAX    7'h7F

// embedded timing reference code
`define LSF_TRS_FF     8'hFF
`define LSF_TRS_00     8'h00
`define LSF_XY_ONE     7
`define LSF_XY_F       6
`define LSF_XY_V       5
`define LSF_XY_H       4

// configuration reset values (line reset on start of active video)
`define LSF_RST_EXT    1'b0
`define LSF_RST_LRS    1'b1
`define LSF_RST_FDS    1'b0
`define LSF_RST_FIELD_INVERT   1'b0
`define LSF_RST_FRS    1'b0
`define LSF_RST_YC     1'b0
`define LSF_RST_HCTL   1'b0
`define LSF_RST_HHI    1'b0
`define LSF_RST_VHI    1'b0

`endif

//--- core/lsf_pkg.sv
// lsf_pkg: types of the line sync and field identification block
// assumes lsf_cfg.svh is on the include path
package lsf_pkg;
  `include "lsf_cfg.svh"

  typedef logic [`LSF_CNT_W-1:0] lsf_cnt_t;
  typedef logic [`LSF_AGE_W-1:0] lsf_age_t;

  typedef enum logic {SD_IDLE, SD_WAIT} lsf_sd_t;

  // software configuration of the channel
  typedef struct packed {
    logic external_control_select;
    logic line_reset_select;
    logic field_detect_select;
    logic field_invert;
    logic frame_reset_select;
    logic yc_mode;
    logic horiz_is_ctrl;
    logic horiz_active_high;
    logic vert_active_high;
  } lsf_cfg_t;

  // decoder pins, synchronous to the pixel clock
  typedef struct packed {
    logic [7:0] data;
    logic       horiz_control_pin;
    logic       vert_control_pin;
    logic       field_indicator_pin;
    logic       capture_enable_pin;
  } lsf_pins_t;

  // control-clock state
  typedef struct packed {
    lsf_cfg_t cfg_r;
  } lsf_ctl_st_t;

  // pixel-clock state
  typedef struct packed {
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] d3;
    logic       h_prev;
    logic       v_prev;
    logic       phase;
    lsf_cnt_t   pixel_counter;
    lsf_cnt_t   line_counter;
    logic       eav_v_prev;
    logic       v_pend;
    logic       field;
    logic       line_start;
    logic       field_start;
    lsf_age_t   hs_age;
    lsf_age_t   sd_cnt;
    lsf_sd_t    sd_state;
  } lsf_pix_st_t;
endpackage

//--- core/lsf_sync2.sv
// lsf_sync2: two flip-flop synchroniser for levels
// assumes each bit is an independent level or a value stable for many cycles
`timescale 1ns/1ns
module lsf_sync2 #(
  parameter int            W   = 1,
  parameter logic [W-1:0]  RST = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
    if (!rstn_i) begin
      meta_nxt = RST;
      q_nxt    = RST;
    end
  end

  always_ff @(posedge clk_i) begin
    meta_r <= meta_nxt;
    q_o    <= q_nxt;
  end
endmodule

//--- core/lsf_top.sv
// lsf_top: line synchronisation and field identification of one capture channel
// assumes decoder pins are synchronous to pix_clk_i; config ports are on clk_i
//
// Contract
// - embedded mode, line reset select clear: reset pixel counter on EAV with H=1.
// - embedded mode, line reset select set: reset pixel counter on SAV with H=0.
// - external mode, line reset select clear: reset on horizontal pin active edge.
// - external mode, line reset select set: reset on horizontal pin inactive edge.
// - after reset the line sync mode is reset on start of active video.
// - pixel counter advances each clock in Y/C, every second in BT.656, when enabled.
// - horizontal pin used as control forces capture enable permanently active.
// - field source: EAV when embedded; pin or sync detector by field detect select.
// - EAV method takes F of first line of field: 0 is field 1.
// - field invert complements the EAV and pin method results.
// - pin method samples field indicator at field start: low is field 1.
// - pin method field start is start or end of vertical blank by frame select.
// - sync method samples hsync at vsync active edge: active gives field 1.
// - hsync and vsync leading edges within 64 cycles count as coincident.
// - embedded, frame select clear: line counter resets at first EAV with V=1.
// - embedded, frame select set: line counter resets at first EAV with V=0.
`timescale 1ns/1ns
module lsf_top
  import lsf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       external_control_select_i,
  input  wire logic       line_reset_select_i,
  input  wire logic       field_detect_select_i,
  input  wire logic       field_invert_i,
  input  wire logic       frame_reset_select_i,
  input  wire logic       yc_mode_i,
  input  wire logic       horiz_is_ctrl_i,
  input  wire logic       horiz_active_high_i,
  input  wire logic       vert_active_high_i,
  output logic            field_o,
  input  wire logic       pix_clk_i,
  input  wire logic [7:0] pix_data_i,
  input  wire logic       horiz_control_pin_i,
  input  wire logic       vert_control_pin_i,
  input  wire logic       field_indicator_pin_i,
  input  wire logic       capture_enable_pin_i,
  output lsf_cnt_t        pixel_counter_o,
  output lsf_cnt_t        line_counter_o,
  output logic            line_start_o,
  output logic            field_start_o,
  output logic            field_pix_o
);

  // reset mode 1: line reset on start of active video
  localparam lsf_cfg_t CFG_RST = '{
    external_control_select: `LSF_RST_EXT,
    line_reset_select:       `LSF_RST_LRS,
    field_detect_select:     `LSF_RST_FDS,
    field_invert:            `LSF_RST_FIELD_INVERT,
    frame_reset_select:      `LSF_RST_FRS,
    yc_mode:                 `LSF_RST_YC,
    horiz_is_ctrl:           `LSF_RST_HCTL,
    horiz_active_high:       `LSF_RST_HHI,
    vert_active_high:        `LSF_RST_VHI
  };

  function automatic logic act_lvl(input logic lvl, input logic hi);
    act_lvl = hi ? lvl : ~lvl;
  endfunction

  // counters wrap silently; a line longer than the counter range restarts at zero
  function automatic lsf_cnt_t cnt_inc(input lsf_cnt_t v);
    cnt_inc = v + 1'b1;
  endfunction

  // ---------------- control clock domain ----------------
  lsf_ctl_st_t c_r;
  lsf_ctl_st_t c_nxt;
  lsf_cfg_t    cfg_in;

  always_comb begin
    cfg_in = '{
      external_control_select: external_control_select_i,
      line_reset_select:       line_reset_select_i,
      field_detect_select:     field_detect_select_i,
      field_invert:            field_invert_i,
      frame_reset_select:      frame_reset_select_i,
      yc_mode:                 yc_mode_i,
      horiz_is_ctrl:           horiz_is_ctrl_i,
      horiz_active_high:       horiz_active_high_i,
      vert_active_high:        vert_active_high_i
    };
    c_nxt.cfg_r = cfg_in;
    if (!rstn_i) begin
      c_nxt.cfg_r = CFG_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    c_r <= c_nxt;
  end

  // field value back into the control domain
  lsf_sync2 #(
    .W   (1),
    .RST (1'b0)
  ) u_field_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .d_i    (field_pix_o),
    .q_o    (field_o)
  );

  // ---------------- pixel clock domain ----------------
  logic     pix_rstn;
  lsf_cfg_t cfg;

  // reset release carried into the pixel domain
  lsf_sync2 #(
    .W   (1),
    .RST (1'b0)
  ) u_rst_sync (
    .clk_i  (pix_clk_i),
    .rstn_i (1'b1),
    .d_i    (rstn_i),
    .q_o    (pix_rstn)
  );

  // configuration bits are quasi-static levels
  // bits may land one pixel clock apart, so software changes them only between frames
  lsf_sync2 #(
    .W   ($bits(lsf_cfg_t)),
    .RST (CFG_RST)
  ) u_cfg_sync (
    .clk_i  (pix_clk_i),
    .rstn_i (pix_rstn),
    .d_i    (c_r.cfg_r),
    .q_o    (cfg)
  );

  lsf_pix_st_t s_r;
  lsf_pix_st_t s_nxt;
  lsf_pins_t   pins;

  always_comb begin
    logic trs;
    logic eav;
    logic sav;
    logic h_act;
    logic h_was;
    logic h_lead;
    logic h_trail;
    logic v_act;
    logic v_was;
    logic v_lead;
    logic v_trail;
    logic line_rst;
    logic cap;
    logic emb_frame;
    logic ext_frame;
    logic xy_v;
    trs       = 1'b0;
    eav       = 1'b0;
    sav       = 1'b0;
    h_act     = 1'b0;
    h_was     = 1'b0;
    h_lead    = 1'b0;
    h_trail   = 1'b0;
    v_act     = 1'b0;
    v_was     = 1'b0;
    v_lead    = 1'b0;
    v_trail   = 1'b0;
    line_rst  = 1'b0;
    cap       = 1'b0;
    emb_frame = 1'b0;
    ext_frame = 1'b0;
    xy_v      = 1'b0;

    pins = '{
      data:                pix_data_i,
      horiz_control_pin:   horiz_control_pin_i,
      vert_control_pin:    vert_control_pin_i,
      field_indicator_pin: field_indicator_pin_i,
      capture_enable_pin:  capture_enable_pin_i
    };

    s_nxt             = s_r;
    s_nxt.line_start  = 1'b0;
    s_nxt.field_start = 1'b0;
    s_nxt.d1          = pins.data;
    s_nxt.d2          = s_r.d1;
    s_nxt.d3          = s_r.d2;
    s_nxt.h_prev      = pins.horiz_control_pin;
    s_nxt.v_prev      = pins.vert_control_pin;

    // embedded code: FF 00 00 XY with the top bit of XY set
    // the pattern never occurs in sample data, so bit 7 alone marks a code
    trs  = (s_r.d3 == `LSF_TRS_FF) && (s_r.d2 == `LSF_TRS_00) &&
           (s_r.d1 == `LSF_TRS_00) && pins.data[`LSF_XY_ONE];
    eav  = trs && pins.data[`LSF_XY_H];
    sav  = trs && !pins.data[`LSF_XY_H];
    xy_v = pins.data[`LSF_XY_V];

    h_act   = act_lvl(pins.horiz_control_pin, cfg.horiz_active_high);
    h_was   = act_lvl(s_r.h_prev, cfg.horiz_active_high);
    h_lead  = h_act && !h_was;
    h_trail = !h_act && h_was;
    v_act   = act_lvl(pins.vert_control_pin, cfg.vert_active_high);
    v_was   = act_lvl(s_r.v_prev, cfg.vert_active_high);
    v_lead  = v_act && !v_was;
    v_trail = !v_act && v_was;

    if (cfg.external_control_select) begin
      line_rst = cfg.line_reset_select ? h_trail : h_lead;
    end else begin
      line_rst = cfg.line_reset_select ? sav : eav;
    end

    cap = cfg.horiz_is_ctrl || pins.capture_enable_pin;

    // phase restarts with each line so sample pairs stay aligned to it
    // pixel counter advance
    if (line_rst) begin
      s_nxt.pixel_counter = '0;
      s_nxt.phase         = 1'b0;
      s_nxt.line_start    = 1'b1;
    end else if (cap) begin
      if (cfg.yc_mode) begin
        s_nxt.pixel_counter = cnt_inc(s_r.pixel_counter);
      end else begin
        s_nxt.phase = !s_r.phase;
        if (s_r.phase) begin
          s_nxt.pixel_counter = cnt_inc(s_r.pixel_counter);
        end
      end
    end

    emb_frame = eav && (cfg.frame_reset_select ? (!xy_v && s_r.eav_v_prev)
                                               : (xy_v && !s_r.eav_v_prev));
    ext_frame = cfg.frame_reset_select ? v_trail : v_lead;

    if (!cfg.external_control_select) begin
      if (eav) begin
        s_nxt.eav_v_prev   = xy_v;
        s_nxt.line_counter = emb_frame ? '0 : cnt_inc(s_r.line_counter);
      end
    end else begin
      if (ext_frame) begin
        s_nxt.v_pend = 1'b1;
      end
      // a vertical edge in the reset cycle itself also starts the frame
      if (line_rst) begin
        s_nxt.v_pend       = 1'b0;
        s_nxt.line_counter = (s_r.v_pend || ext_frame) ? '0 : cnt_inc(s_r.line_counter);
      end
    end

    // hsync age for coincidence ahead of vsync
    // saturates so a stale hsync never looks recent
    if (h_lead) begin
      s_nxt.hs_age = '0;
    end else if (s_r.hs_age != `LSF_AGE_MAX) begin
      s_nxt.hs_age = s_r.hs_age + 1'b1;
    end

    if (!cfg.external_control_select) begin
      s_nxt.sd_state = SD_IDLE;
      if (emb_frame) begin
        s_nxt.field       = pins.data[`LSF_XY_F] ^ cfg.field_invert;
        s_nxt.field_start = 1'b1;
      end
    end else if (!cfg.field_detect_select) begin
      s_nxt.sd_state = SD_IDLE;
      if (ext_frame) begin
        s_nxt.field       = pins.field_indicator_pin ^ cfg.field_invert;
        s_nxt.field_start = 1'b1;
      end
    end else begin
      case (s_r.sd_state)
        SD_IDLE: begin
          if (v_lead) begin
            if (h_act || (s_r.hs_age < `LSF_SKEW_CYC)) begin
              s_nxt.field       = 1'b0;
              s_nxt.field_start = 1'b1;
            end else begin
              s_nxt.sd_state = SD_WAIT;
              s_nxt.sd_cnt   = '0;
            end
          end
        end
        SD_WAIT: begin
          // window closes on the 64th cycle after the vsync edge
          // hsync lead within window
          if (h_lead) begin
            s_nxt.field       = 1'b0;
            s_nxt.field_start = 1'b1;
            s_nxt.sd_state    = SD_IDLE;
          end else if (lsf_age_t'(s_r.sd_cnt + 1'b1) == `LSF_SKEW_CYC) begin
            s_nxt.field       = 1'b1;
            s_nxt.field_start = 1'b1;
            s_nxt.sd_state    = SD_IDLE;
          end else begin
            s_nxt.sd_cnt = s_r.sd_cnt + 1'b1;
          end
        end
        default: begin
          s_nxt.sd_state = SD_IDLE;
        end
      endcase
    end

    // pixel reset arrives through its own synchroniser
    if (!pix_rstn) begin
      s_nxt          = '0;
      s_nxt.hs_age   = `LSF_AGE_MAX;
      s_nxt.sd_state = SD_IDLE;
    end
  end

  always_ff @(posedge pix_clk_i) begin
    s_r <= s_nxt;
  end

  assign pixel_counter_o = s_r.pixel_counter;
  assign line_counter_o  = s_r.line_counter;
  assign line_start_o    = s_r.line_start;
  assign field_start_o   = s_r.field_start;
  assign field_pix_o     = s_r.field;

endmodule

//--- sim/lsf_dec_model.sv
// lsf_dec_model: video decoder driving pixel bytes and control pins
// assumes a free-running pixel clock from the bench
`timescale 1ns/1ns
module lsf_dec_model
  import lsf_pkg::*;
(
  input  wire logic pix_clk_i,
  output lsf_pins_t pins_o
);
  initial pins_o = '{data: 8'h10, capture_enable_pin: 1'b1, default: '0};
  task automatic pix(input int n);
    repeat (n) @(posedge pix_clk_i);
    #2;
  endtask
  task automatic put(input logic [7:0] d);
    pix(1);
    pins_o.data = d;
  endtask
  task automatic code(input logic [7:0] xy);
    put(8'hFF);
    put(8'h00);
    put(8'h00);
    put(xy);
    put(8'h10);
  endtask
  task automatic ctl(input logic h, input logic v, input logic f, input logic c);
    pix(1);
    pins_o.horiz_control_pin = h;
    pins_o.vert_control_pin = v;
    pins_o.field_indicator_pin = f;
    pins_o.capture_enable_pin = c;
  endtask
endmodule

//--- sim/lsf_chk_sva.sv
// lsf_chk: port-level checker for lsf_top
// assumes bind from the bench top and config held still around traffic
`timescale 1ns/1ns
module lsf_chk
  import lsf_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       external_control_select_i,
  input wire logic       line_reset_select_i,
  input wire logic       field_detect_select_i,
  input wire logic       field_invert_i,
  input wire logic       frame_reset_select_i,
  input wire logic       yc_mode_i,
  input wire logic       horiz_is_ctrl_i,
  input wire logic       horiz_active_high_i,
  input wire logic       vert_active_high_i,
  input wire logic       field_o,
  input wire logic       pix_clk_i,
  input wire logic [7:0] pix_data_i,
  input wire logic       horiz_control_pin_i,
  input wire logic       vert_control_pin_i,
  input wire logic       field_indicator_pin_i,
  input wire logic       capture_enable_pin_i,
  input wire lsf_cnt_t   pixel_counter_o,
  input wire lsf_cnt_t   line_counter_o,
  input wire logic       line_start_o,
  input wire logic       field_start_o,
  input wire logic       field_pix_o
);
  sequence trs_s;
    pix_data_i == 8'hFF ##1 pix_data_i == 8'h00 ##1 pix_data_i == 8'h00;
  endsequence
  code_reset_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    trs_s ##1 (pix_data_i[7] && !external_control_select_i && pix_data_i[4] != line_reset_select_i)
    |=> line_start_o && pixel_counter_o == 12'h000) else $error("code did not restart the line");
  line_zero_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    line_start_o |-> pixel_counter_o == 12'h000) else $error("line start with nonzero count");
  zero_cause_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    pixel_counter_o == 12'h000 && $past(pixel_counter_o) != 12'h000 |-> line_start_o)
    else $error("count cleared without line start");
  cnt_step_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    $changed(pixel_counter_o) |-> pixel_counter_o == $past(pixel_counter_o) + 12'h001
    || pixel_counter_o == 12'h000) else $error("pixel count jumped");
  cnt_hold_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    $past(!capture_enable_pin_i && !horiz_is_ctrl_i) && !line_start_o |-> $stable(pixel_counter_o))
    else $error("count moved while capture disabled");
  lcnt_step_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    $changed(line_counter_o) |-> line_counter_o == $past(line_counter_o) + 12'h001
    || line_counter_o == 12'h000) else $error("line count jumped");
  field_hold_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    $changed(field_pix_o) |-> field_start_o) else $error("field changed without field start");
  fstart_pulse_a: assert property (@(posedge pix_clk_i) disable iff (!rstn_i)
    field_start_o |=> !field_start_o) else $error("field start longer than one cycle");
  field_cross_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    field_o != field_pix_o |-> ##[1:4] field_o == field_pix_o) else $error("field not carried over");
endmodule

//--- sim/lsf_top_test.sv
// lsf_top_test: scenario bench for lsf_top with a decoder model
// assumes a 50 MHz control clock and a free 30 ns pixel clock
`timescale 1ns/1ns
module lsf_top_test
  import lsf_pkg::*;
;
  logic      clk_i, rstn_i, pix_clk_i, h;
  logic      field_o, line_start_o, field_start_o, field_pix_o;
  lsf_cfg_t  cfg;
  lsf_pins_t pins;
  lsf_cnt_t  pixel_counter_o, line_counter_o;
  int        errors, checks_done;
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    pix_clk_i = 1'b0;
    #7;
    forever #15 pix_clk_i = ~pix_clk_i;
  end
  lsf_dec_model u_dec (.pix_clk_i(pix_clk_i), .pins_o(pins));
  lsf_top u_lsf_top (.clk_i(clk_i), .rstn_i(rstn_i), .external_control_select_i(cfg[8]),
    .line_reset_select_i(cfg[7]), .field_detect_select_i(cfg[6]), .field_invert_i(cfg[5]),
    .frame_reset_select_i(cfg[4]), .yc_mode_i(cfg[3]), .horiz_is_ctrl_i(cfg[2]),
    .horiz_active_high_i(cfg[1]), .vert_active_high_i(cfg[0]), .field_o(field_o), .pix_clk_i(pix_clk_i),
    .pix_data_i(pins.data), .horiz_control_pin_i(pins.horiz_control_pin),
    .vert_control_pin_i(pins.vert_control_pin), .field_indicator_pin_i(pins.field_indicator_pin),
    .capture_enable_pin_i(pins.capture_enable_pin), .pixel_counter_o(pixel_counter_o),
    .line_counter_o(line_counter_o), .line_start_o(line_start_o), .field_start_o(field_start_o),
    .field_pix_o(field_pix_o));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cfg_set(input logic [8:0] v);
    @(posedge clk_i);
    #2 cfg = v;
    repeat (3) @(posedge clk_i);
    u_dec.pix(4);
  endtask
  // bounded look for a line start, stops on the first one
  task automatic ls_seen(output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 3 && !hit; i++) begin
      u_dec.pix(1);
      hit = (line_start_o === 1'b1);
    end
  endtask
  task automatic t_sav();
    u_dec.code(8'h90);
    chk(line_start_o, 1'b0);
    u_dec.code(8'h80);
    chk(line_start_o, 1'b1);
    u_dec.pix(10);
    chk(pixel_counter_o, 12'h005);
  endtask
  task automatic t_eav();
    cfg_set(9'h008);
    u_dec.code(8'h90);
    chk(line_start_o, 1'b1);
    u_dec.pix(10);
    chk(pixel_counter_o, 12'h00A);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b0);
    u_dec.pix(5);
    chk(pixel_counter_o, 12'h00B);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    u_dec.code(8'h90);
    u_dec.code(8'hF0);
    u_dec.pix(2);
    chk(line_counter_o, 12'h000);
    chk(field_pix_o, 1'b1);
    u_dec.code(8'hF0);
    chk(line_counter_o, 12'h001);
    repeat (4) @(posedge clk_i);
    #2;
    chk(field_o, 1'b1);
    cfg_set(9'h028);
    u_dec.code(8'h90);
    u_dec.code(8'hF0);
    u_dec.pix(2);
    chk(field_pix_o, 1'b0);
    cfg_set(9'h018);
    u_dec.code(8'hF0);
    u_dec.code(8'hD0);
    u_dec.pix(2);
    chk(line_counter_o, 12'h000);
    chk(field_pix_o, 1'b1);
    cfg_set(9'h058);
    u_dec.code(8'hF0);
    u_dec.code(8'h90);
    u_dec.pix(2);
    chk(field_pix_o, 1'b0);
  endtask
  task automatic t_ext();
    cfg_set(9'h10E);
    u_dec.ctl(1'b1, 1'b0, 1'b0, 1'b0);
    ls_seen(h);
    chk(h, 1'b1);
    cfg_set(9'h18E);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b0);
    ls_seen(h);
    chk(h, 1'b1);
    u_dec.pix(4);
    chk(pixel_counter_o, 12'h004);
    u_dec.ctl(1'b1, 1'b0, 1'b0, 1'b0);
    ls_seen(h);
    chk(h, 1'b0);
  endtask
  task automatic t_fid();
    u_dec.ctl(1'b0, 1'b0, 1'b1, 1'b1);
    cfg_set(9'h109);
    u_dec.ctl(1'b0, 1'b1, 1'b1, 1'b1);
    u_dec.pix(1);
    chk(field_start_o, 1'b1);
    u_dec.pix(2);
    chk(field_pix_o, 1'b1);
    u_dec.ctl(1'b1, 1'b1, 1'b1, 1'b1);
    ls_seen(h);
    chk(h, 1'b0);
    u_dec.ctl(1'b0, 1'b1, 1'b1, 1'b1);
    ls_seen(h);
    chk(h, 1'b1);
    cfg_set(9'h119);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    u_dec.pix(3);
    chk(field_pix_o, 1'b0);
    u_dec.ctl(1'b0, 1'b1, 1'b1, 1'b1);
    u_dec.pix(3);
    chk(field_pix_o, 1'b0);
    cfg_set(9'h139);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    u_dec.pix(3);
    chk(field_pix_o, 1'b1);
  endtask
  task automatic t_sync();
    cfg_set(9'h14B);
    u_dec.ctl(1'b1, 1'b0, 1'b0, 1'b1);
    u_dec.ctl(1'b1, 1'b1, 1'b0, 1'b1);
    u_dec.pix(3);
    chk(field_pix_o, 1'b0);
    u_dec.pix(70);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    u_dec.ctl(1'b0, 1'b1, 1'b0, 1'b1);
    u_dec.pix(70);
    chk(field_pix_o, 1'b1);
    u_dec.ctl(1'b0, 1'b0, 1'b0, 1'b1);
    u_dec.ctl(1'b0, 1'b1, 1'b0, 1'b1);
    u_dec.pix(30);
    u_dec.ctl(1'b1, 1'b1, 1'b0, 1'b1);
    u_dec.pix(3);
    chk(field_pix_o, 1'b0);
  endtask
  initial begin
    #1000000;
    errors++;
    finish_test();
  end
  initial begin
    errors = 0;
    checks_done = 0;
    rstn_i = 1'b0;
    cfg = 9'h080;
    repeat (10) @(posedge clk_i);
    #2 rstn_i = 1'b1;
    u_dec.pix(4);
    t_sav();
    t_eav();
    t_ext();
    t_fid();
    t_sync();
    finish_test();
  end
endmodule
bind lsf_top lsf_chk u_lsf_chk (.clk_i(clk_i), .rstn_i(rstn_i),
  .external_control_select_i(external_control_select_i), .line_reset_select_i(line_reset_select_i),
  .field_detect_select_i(field_detect_select_i), .field_invert_i(field_invert_i),
  .frame_reset_select_i(frame_reset_select_i), .yc_mode_i(yc_mode_i), .horiz_is_ctrl_i(horiz_is_ctrl_i),
  .horiz_active_high_i(horiz_active_high_i), .vert_active_high_i(vert_active_high_i), .field_o(field_o),
  .pix_clk_i(pix_clk_i), .pix_data_i(pix_data_i), .horiz_control_pin_i(horiz_control_pin_i),
  .vert_control_pin_i(vert_control_pin_i), .field_indicator_pin_i(field_indicator_pin_i),
  .capture_enable_pin_i(capture_enable_pin_i), .pixel_counter_o(pixel_counter_o),
  .line_counter_o(line_counter_o), .line_start_o(line_start_o), .field_start_o(field_start_o),
  .field_pix_o(field_pix_o));
